// file: logic/tcp_pkg.sv
// Package with register map, field layout, reset values and clock-select codes of the timer block.
// Overview of operation
// - Interval mode: counter equal to buffer toggles output, flags match, clears counter.
// - Capture mode: capture edge copies counter into reference, then clears counter.
// - Capture edge is selectable as rising or falling.
// - Capture mode raises overflow each time the counter wraps past 255.
// - Buffer loads reference on counter-clear write, on match and on overflow.
// - Match comparator uses the buffer copy, never the reference register directly.
// - Mode bit 0 selects interval, 1 selects capture; overflow only in capture.
// - Writing 1 to counter-clear clears counter; bit reads back 0; 0 does nothing.
// - Clock code 0000 stops, 0101 external rising, 0110 external falling; other codes below 1000 unavailable.
// - Timer B codes 1000 to 1111 divide system clock by 2 up to 2048.
// - Timer A prescaler divides system clock by 1 up to 1024.
// - Flags are requested only when enabled and clear on service acknowledge.
// - PWM period is period-high bits 1:0 above timer A reference.
// - PWM duty is period-high bits 3:2 above the duty low register.
// - Period lasts period plus one ticks; duty lasts duty plus one ticks.
// - A new duty value takes effect only at the next period start.
// - Changing only the period keeps the absolute duty time.
// - Polarity bit selects whether the duty portion is high or low.
// - Duty equal period holds active level; duty zero holds inactive level.
// - Timer A codes 0101/0110 external edges, 1000 to 1111 divided clocks, 0000 stop.
package tcp_pkg;
  // Register offsets on the 8-bit register port.
  localparam logic [7:0] TA_SCR_OFF = 8'hD0;
  localparam logic [7:0] TA_CNT_OFF = 8'hD1;
  localparam logic [7:0] TA_REF_OFF = 8'hD2;
  localparam logic [7:0] TB_SCR_OFF = 8'hD3;
  localparam logic [7:0] TB_CNT_OFF = 8'hD4;
  localparam logic [7:0] TB_REF_OFF = 8'hD5;
  localparam logic [7:0] IRQ_EN_OFF = 8'hD6;
  localparam logic [7:0] IRQ_FLAG_OFF = 8'hD7;
  localparam logic [7:0] CAP_EDGE_OFF = 8'hD8;
  localparam logic [7:0] PWM_SCR_OFF = 8'hE2;
  localparam logic [7:0] PWM_PDH_OFF = 8'hE3;
  localparam logic [7:0] PWM_DUTY_OFF = 8'hE6;
  // Field positions.
  localparam int MS_BIT = 5;
  localparam int CC_BIT = 4;
  localparam int POL_BIT = 7;
  localparam int PWMS_BIT = 6;
  // Reset values.
  localparam logic [7:0] SCR_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam logic [1:0] CAP_EDGE_RST = 2'h3;
  localparam logic [3:0] PWM_PDH_RST = 4'h0;
  localparam logic [7:0] PWM_DUTY_RST = 8'hFF;
  // Clock-select codes; codes with bit 3 set pick a prescaler tap.
  typedef enum logic [3:0] {
    TCP_CS_STOP = 4'h0,
    TCP_CS_EXT_RISE = 4'h5,
    TCP_CS_EXT_FALL = 4'h6
  } tcp_cs_t;
  localparam int PRE_W = 11;
  // Prescaler taps as powers of two for the eight divided-clock codes.
  localparam logic [7:0][3:0] TA_SHIFTS = {4'hA, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [7:0][3:0] TB_SHIFTS = {4'hB, 4'h9, 4'h7, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
endpackage : tcp_pkg

// file: logic/tcp_tick.sv
// Clock-source selector: prescaler taps and synchronised external clock edges.
`timescale 1ns/1ps
`default_nettype none
module tcp_tick #(
  parameter logic [7:0][3:0] SHIFTS = tcp_pkg::TA_SHIFTS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [3:0] clock_select,
  input wire logic ext_clock_pin,
  output logic tick
);
  import tcp_pkg::*;

  logic [PRE_W-1:0] pre;
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;

  // True when the low bits of the prescaler are all ones, once per 2**sh clocks.
  function automatic logic pre_hit(input logic [PRE_W-1:0] c, input logic [3:0] sh);
    logic [PRE_W:0] m;
    m = ({{PRE_W{1'b0}}, 1'b1} << sh) - {{PRE_W{1'b0}}, 1'b1};
    return (c & m[PRE_W-1:0]) == m[PRE_W-1:0];
  endfunction : pre_hit

  // Free-running prescaler; all taps share it so no divider ever restarts.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
    end else if (ce) begin
      pre <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // The pin is asynchronous; two stages settle it, the third gives the edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else if (ce) begin
      ext_s1 <= ext_clock_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // One-cycle count enable for the selected source.
  always_comb begin
    tick = 1'b0;
    if (clock_select == TCP_CS_STOP) begin
      tick = 1'b0;
    end else if (clock_select == TCP_CS_EXT_RISE) begin
      tick = ce & ext_s2 & ~ext_s3;
    end else if (clock_select == TCP_CS_EXT_FALL) begin
      tick = ce & ~ext_s2 & ext_s3;
    end else if (clock_select[3]) begin
      tick = ce & pre_hit(pre, SHIFTS[clock_select[2:0]]);
    end
  end
endmodule : tcp_tick
`default_nettype wire

// file: logic/tcp_top.sv
// Two 8-bit interval/capture timers with a 10-bit PWM sharing timer A.
`timescale 1ns/1ps
`default_nettype none
module tcp_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic ext_clock_a,
  input wire logic ext_clock_b,
  input wire logic capture_a_input,
  input wire logic capture_b_input,
  input wire logic [3:0] irq_ack,
  output logic [3:0] irq_req,
  output logic timer_a_toggle_out,
  output logic timer_b_toggle_out
);
  import tcp_pkg::*;

  // Index 0 is timer A, index 1 is timer B.
  logic [5:0] scr [2];
  logic [7:0] cnt [2];
  logic [7:0] ref_q [2];
  logic [7:0] buf_q [2];
  logic [1:0] tog;
  logic [1:0] tick;
  logic [1:0] clr_wr;
  logic [1:0] cap_mode;
  logic [1:0] match_ev;
  logic [1:0] ovf_ev;
  logic [1:0] cap_ev;
  logic [1:0] cap_s1;
  logic [1:0] cap_s2;
  logic [1:0] cap_s3;
  logic [1:0] cap_edge;
  logic [3:0] irq_en;
  logic [3:0] irq_flag;
  logic [3:0] irq_set;
  logic pwm_pol;
  logic pwm_sel;
  logic [3:0] pwm_pdh;
  logic [7:0] pwm_duty;
  logic [9:0] pwm_cnt;
  logic [9:0] duty_l;
  logic [9:0] period;
  logic [9:0] duty;
  logic pwm_level;
  logic pwm_pin;
  logic [7:0] next_rdata;

  // Write decode shared by every register.
  function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] off);
    return w && (a == off);
  endfunction : wr_hit

  // Clock sources of both timers.
  tcp_tick #(
    .SHIFTS(TA_SHIFTS)
  ) u_tick_a (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .clock_select(scr[0][3:0]),
    .ext_clock_pin(ext_clock_a),
    .tick(tick[0])
  );

  tcp_tick #(
    .SHIFTS(TB_SHIFTS)
  ) u_tick_b (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .clock_select(scr[1][3:0]),
    .ext_clock_pin(ext_clock_b),
    .tick(tick[1])
  );

  // Capture pins come from outside, so they are synchronised before edge detection.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_s1 <= 2'h0;
      cap_s2 <= 2'h0;
      cap_s3 <= 2'h0;
    end else if (ce) begin
      cap_s1 <= {capture_b_input, capture_a_input};
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  // Timer events; timer A's match and overflow are held while it runs as the PWM.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      clr_wr[i] = ce && wr_hit(wr, addr, (i == 0) ? TA_SCR_OFF : TB_SCR_OFF) && wdata[CC_BIT];
      cap_mode[i] = scr[i][MS_BIT];
      match_ev[i] = tick[i] && !cap_mode[i] && (cnt[i] == buf_q[i])
                    && !(i == 0 && pwm_sel);
      ovf_ev[i] = tick[i] && cap_mode[i] && (cnt[i] == 8'hFF)
                  && !(i == 0 && pwm_sel);
      cap_ev[i] = ce && cap_mode[i] && (cap_edge[i] ? (cap_s2[i] & ~cap_s3[i])
                                                   : (~cap_s2[i] & cap_s3[i]));
    end
  end

  // Control registers; the counter-clear bit is a strobe and is never stored.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scr[0] <= SCR_RST[5:0];
      scr[1] <= SCR_RST[5:0];
      irq_en <= IRQ_EN_RST;
      cap_edge <= CAP_EDGE_RST;
    end else if (ce) begin
      if (wr_hit(wr, addr, TA_SCR_OFF)) begin
        scr[0] <= {wdata[MS_BIT], 1'b0, wdata[3:0]};
      end
      if (wr_hit(wr, addr, TB_SCR_OFF)) begin
        scr[1] <= {wdata[MS_BIT], 1'b0, wdata[3:0]};
      end
      if (wr_hit(wr, addr, IRQ_EN_OFF)) begin
        irq_en <= wdata[3:0];
      end
      if (wr_hit(wr, addr, CAP_EDGE_OFF)) begin
        cap_edge <= wdata[1:0];
      end
    end
  end

  // Reference registers; a capture wins over a software write in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_q[0] <= REF_RST;
      ref_q[1] <= REF_RST;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (cap_ev[i]) begin
          ref_q[i] <= cnt[i];
        end else if (wr_hit(wr, addr, (i == 0) ? TA_REF_OFF : TB_REF_OFF)) begin
          ref_q[i] <= wdata;
        end
      end
    end
  end

  // Compare buffers reload at start, match and overflow, so a new reference
  // written mid-count never truncates the interval in progress.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_q[0] <= REF_RST;
      buf_q[1] <= REF_RST;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (clr_wr[i] || match_ev[i] || ovf_ev[i]) begin
          buf_q[i] <= ref_q[i];
        end
      end
    end
  end

  // Counters: clear strobe, then capture, then match, then plain count.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt[0] <= 8'h00;
      cnt[1] <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (clr_wr[i]) begin
          cnt[i] <= 8'h00;
        end else if (cap_ev[i]) begin
          cnt[i] <= 8'h00;
        end else if (match_ev[i]) begin
          cnt[i] <= 8'h00;
        end else if (tick[i] && !(i == 0 && pwm_sel)) begin
          cnt[i] <= cnt[i] + 8'h01;
        end
      end
    end
  end

  // Toggle outputs flip on every match.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tog <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (match_ev[i]) begin
          tog[i] <= ~tog[i];
        end
      end
    end
  end

  // Flag order: {b_ovf, b_match, a_ovf, a_match}; a set beats an acknowledge.
  assign irq_set = {ovf_ev[1], match_ev[1], ovf_ev[0], match_ev[0]} & irq_en;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_flag <= 4'h0;
    end else if (ce) begin
      irq_flag <= (irq_flag & ~irq_ack) | irq_set;
    end
  end

  assign irq_req = irq_flag;

  // PWM control registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_pol <= 1'b0;
      pwm_sel <= 1'b0;
      pwm_pdh <= PWM_PDH_RST;
      pwm_duty <= PWM_DUTY_RST;
    end else if (ce) begin
      if (wr_hit(wr, addr, PWM_SCR_OFF)) begin
        pwm_pol <= wdata[POL_BIT];
        pwm_sel <= wdata[PWMS_BIT];
      end
      if (wr_hit(wr, addr, PWM_PDH_OFF)) begin
        pwm_pdh <= wdata[3:0];
      end
      if (wr_hit(wr, addr, PWM_DUTY_OFF)) begin
        pwm_duty <= wdata;
      end
    end
  end

  assign period = {pwm_pdh[1:0], ref_q[0]};
  assign duty = {pwm_pdh[3:2], pwm_duty};

  // The period is compared live so a period change keeps the duty time,
  // while the duty is latched only at a period boundary.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_cnt <= 10'h000;
      duty_l <= {2'h0, PWM_DUTY_RST};
    end else if (ce) begin
      if (!pwm_sel || clr_wr[0]) begin
        pwm_cnt <= 10'h000;
        duty_l <= duty;
      end else if (tick[0]) begin
        if (pwm_cnt >= period) begin
          pwm_cnt <= 10'h000;
          duty_l <= duty;
        end else begin
          pwm_cnt <= pwm_cnt + 10'h001;
        end
      end
    end
  end

  // Active for duty+1 ticks; a zero duty never goes active.
  assign pwm_level = pwm_pol ~^ ((duty_l != 10'h000) && (pwm_cnt <= duty_l));

  // Output pins are registered; timer A's pin carries the PWM when selected.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_pin <= 1'b0;
    end else if (ce) begin
      pwm_pin <= pwm_sel ? pwm_level : tog[0];
    end
  end

  assign timer_a_toggle_out = pwm_pin;
  assign timer_b_toggle_out = tog[1];

  // Read mux; unmapped addresses read zero, the clear bit always reads zero.
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      TA_SCR_OFF: next_rdata = {2'h0, scr[0][5], 1'b0, scr[0][3:0]};
      TA_CNT_OFF: next_rdata = cnt[0];
      TA_REF_OFF: next_rdata = ref_q[0];
      TB_SCR_OFF: next_rdata = {2'h0, scr[1][5], 1'b0, scr[1][3:0]};
      TB_CNT_OFF: next_rdata = cnt[1];
      TB_REF_OFF: next_rdata = ref_q[1];
      IRQ_EN_OFF: next_rdata = {4'h0, irq_en};
      IRQ_FLAG_OFF: next_rdata = {4'h0, irq_flag};
      CAP_EDGE_OFF: next_rdata = {6'h00, cap_edge};
      PWM_SCR_OFF: next_rdata = {pwm_pol, pwm_sel, 6'h00};
      PWM_PDH_OFF: next_rdata = {4'h0, pwm_pdh};
      PWM_DUTY_OFF: next_rdata = pwm_duty;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // A match clears the counter and flips the toggle in the same edge.
  match_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    match_ev[1] && !clr_wr[1] && !cap_ev[1] |=> cnt[1] == 8'h00 && tog[1] != $past(tog[1]))
    else $error("match did not clear counter and toggle output");

  // A capture copies the old count and restarts; only timer B's capture is checked here.
  capture_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    cap_ev[1] && !clr_wr[1] |=> ref_q[1] == $past(cnt[1]) && cnt[1] == 8'h00)
    else $error("capture did not load reference and clear counter");

  // Overflow at 255 sets an enabled flag and wraps.
  ovf_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf_ev[1] && irq_en[3] && !clr_wr[1] && !cap_ev[1]
    |=> irq_flag[3] && cnt[1] == 8'h00)
    else $error("overflow did not set flag and wrap counter");

  // The clear strobe loads the buffer from the reference.
  buf_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    clr_wr[0] |=> buf_q[0] == $past(ref_q[0]) && cnt[0] == 8'h00)
    else $error("clear strobe did not load buffer");

  // A stopped counter does not move without an event.
  stop_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    scr[1][3:0] == 4'h0 && !clr_wr[1] && !cap_ev[1] |=> $stable(cnt[1]))
    else $error("stopped counter moved");

  // An acknowledge clears a flag that is not set again.
  ack_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    ce && irq_ack[0] && !irq_set[0] |=> !irq_flag[0])
    else $error("acknowledge did not clear flag");

  // Duty only changes at a period boundary while the PWM runs.
  duty_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    pwm_sel && !clr_wr[0] && !(tick[0] && pwm_cnt >= period) ##1 pwm_sel |-> $stable(duty_l))
    else $error("duty changed inside a period");

  // Full duty holds the active level, zero duty the inactive one.
  pwm_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
    pwm_sel && pwm_cnt <= period && duty_l != 10'h000 && duty_l == period
    |-> pwm_level == pwm_pol)
    else $error("full duty did not hold active level");

  pwm_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
    pwm_sel && duty_l == 10'h000 |-> pwm_level == !pwm_pol)
    else $error("zero duty did not hold inactive level");
endmodule : tcp_top
`default_nettype wire

// file: tb/tcp_cpu_model.sv
// CPU interrupt service model that acknowledges pending request flags.
`timescale 1ns/1ps
`default_nettype none
module tcp_cpu_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic svc_on,
  input wire logic [3:0] irq_req,
  output logic [3:0] irq_ack
);
  logic [3:0] busy;

  // Entering a service routine pulses the acknowledge once per request.
  // The busy mask stops a second pulse while the flag is still seen high.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ack <= 4'h0;
      busy <= 4'h0;
    end else begin
      irq_ack <= svc_on ? (irq_req & ~busy & ~irq_ack) : 4'h0;
      busy <= irq_req & (busy | irq_ack);
    end
  end
endmodule : tcp_cpu_model
`default_nettype wire

// file: tb/test_timer_capture_pwm.sv
// Self-checking bench for the timer block against an integer reference model.
`timescale 1ns/1ps
`default_nettype none
module test_timer_capture_pwm;
  import tcp_pkg::*;
  logic clk, arst_n, wr, rd, ext_a, ext_b, cap_a, cap_b, svc_on, lv, act, ce;
  logic [7:0] addr, wdata, rdata, seed;
  logic [3:0] irq_req, irq_ack;
  logic out_a, out_b;
  int err_total, check_count, n, m, k, per, dut_v;
  // Divide ratios of the eight prescaler codes for each timer.
  int div_a[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  int div_b[8] = '{2, 4, 8, 16, 32, 128, 512, 2048};
  // PWM cases packed as polarity, period/duty high bits, duty low byte.
  logic [12:0] pt[4] = '{13'h1120, 13'h0503, 13'h1505, 13'h0100};

  tcp_top tcp_top_inst (
    .clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_clock_a(ext_a), .ext_clock_b(ext_b), .capture_a_input(cap_a),
    .capture_b_input(cap_b), .irq_ack(irq_ack), .irq_req(irq_req),
    .timer_a_toggle_out(out_a), .timer_b_toggle_out(out_b)
  );

  tcp_cpu_model tcp_cpu_model_inst (
    .clk(clk), .arst_n(arst_n), .svc_on(svc_on), .irq_req(irq_req), .irq_ack(irq_ack)
  );

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_write

  // Read data is looked at mid-cycle, the only cycle in which it stands.
  task automatic bus_read(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp, what);
  endtask : bus_read

  // Counts cycles until the chosen output shows the wanted level, bounded.
  task automatic wait_lvl(input bit sel_b, input logic lvl, output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (((sel_b ? out_b : out_a) !== lvl) && cyc < 5000);
  endtask : wait_lvl

  // Measures one whole gap between two output toggles, skipping the partial one.
  task automatic toggle_gap(input bit sel_b, output int cyc);
    logic v;
    @(negedge clk);
    v = sel_b ? out_b : out_a;
    wait_lvl(sel_b, ~v, cyc);
    wait_lvl(sel_b, v, cyc);
  endtask : toggle_gap

  // Each pulse holds both count clocks high and low long enough for the synchronisers.
  task automatic ext_pulses(input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      ext_a <= 1'b1;
      ext_b <= 1'b1;
      repeat (4) @(posedge clk);
      ext_a <= 1'b0;
      ext_b <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : ext_pulses

  // Watchdog sized well above the expected run of about 15000 cycles.
  initial begin
    #(60000 * 8);
    err_total++;
    wrap_up();
  end

  // Main sequence; expectations come from the integer model above.
  initial begin
    {arst_n, wr, rd, ext_a, ext_b, cap_a, cap_b, svc_on} = 8'h00;
    addr = 8'h00;
    ce = 1'b1;
    wdata = 8'h00;
    err_total = 0;
    check_count = 0;
    seed = 8'h17;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    bus_read(TB_SCR_OFF, SCR_RST, "b_scr reset");
    bus_read(CAP_EDGE_OFF, {6'h00, CAP_EDGE_RST}, "edge reset");
    bus_read(8'h10, 8'h00, "unmapped");
    seed = lfsr(seed);
    n = seed % 200 + 4;
    bus_write(TA_REF_OFF, n[7:0]);
    bus_write(IRQ_EN_OFF, 8'h03);
    bus_write(TA_SCR_OFF, 8'h18);
    toggle_gap(1'b0, m);
    check(m, n + 1, "interval");
    lv = out_a;
    bus_write(TA_REF_OFF, 8'h0A);
    wait_lvl(1'b0, ~lv, k);
    check(k + 1, n + 1, "buffered ref");
    wait_lvl(1'b0, lv, k);
    check(k, 11, "reloaded ref");
    bus_read(TA_SCR_OFF, 8'h08, "clear self");
    bus_write(TA_SCR_OFF, 8'h00);
    @(negedge clk);
    check(irq_req[1:0], 2'b01, "a flags");
    svc_on <= 1'b1;
    repeat (4) @(posedge clk);
    svc_on <= 1'b0;
    @(negedge clk);
    check(irq_req[0], 1'b0, "a match ack");
    bus_write(IRQ_EN_OFF, 8'h08);
    bus_write(TA_REF_OFF, 8'h00);
    bus_write(TB_REF_OFF, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bus_write(TA_SCR_OFF, 8'h18 | 8'(i));
      bus_write(TB_SCR_OFF, 8'h18 | 8'(i));
      toggle_gap(1'b0, m);
      check(m, div_a[i], "div a");
      toggle_gap(1'b1, m);
      check(m, div_b[i], "div b");
    end
    check(irq_req[2], 1'b0, "b match masked");
    // A nonzero reference keeps matches from hiding a counter that fails to stop.
    bus_write(TB_REF_OFF, 8'hF0);
    foreach (div_a[i]) begin
      if (i < 6) begin
        bus_write(TB_SCR_OFF, 8'h10 | ((i == 5) ? 8'h07 : 8'(i)));
        repeat (40) @(posedge clk);
        bus_read(TB_CNT_OFF, 8'h00, "stopped");
      end
    end
    bus_write(TB_SCR_OFF, 8'h35);
    seed = lfsr(seed);
    k = seed % 40 + 1;
    ext_pulses(k);
    cap_b <= 1'b1;
    repeat (8) @(posedge clk);
    bus_read(TB_REF_OFF, k[7:0], "capture rise");
    bus_read(TB_CNT_OFF, 8'h00, "capture clear");
    bus_write(CAP_EDGE_OFF, 8'h01);
    bus_write(TB_SCR_OFF, 8'h36);
    seed = lfsr(seed);
    k = seed % 40 + 1;
    ext_pulses(k);
    cap_b <= 1'b0;
    repeat (8) @(posedge clk);
    bus_read(TB_REF_OFF, k[7:0], "capture fall");
    bus_write(TB_SCR_OFF, 8'h35);
    ext_pulses(255);
    bus_read(TB_CNT_OFF, 8'hFF, "count 255");
    check(irq_req[3], 1'b0, "no wrap yet");
    // A pulse that comes and goes while the enable is low must leave no count.
    @(posedge clk);
    ce <= 1'b0;
    ext_pulses(1);
    ce <= 1'b1;
    bus_read(TB_CNT_OFF, 8'hFF, "frozen count");
    ext_pulses(1);
    repeat (8) @(posedge clk);
    bus_read(TB_CNT_OFF, 8'h00, "wrapped");
    check(irq_req[3], 1'b1, "wrap flag");
    svc_on <= 1'b1;
    repeat (4) @(posedge clk);
    svc_on <= 1'b0;
    @(negedge clk);
    check(irq_req[3], 1'b0, "wrap ack");
    for (int i = 0; i < 4; i++) begin
      bus_write(TA_SCR_OFF, 8'h00);
      bus_write(TA_REF_OFF, 8'h05);
      bus_write(PWM_PDH_OFF, {4'h0, pt[i][11:8]});
      bus_write(PWM_DUTY_OFF, pt[i][7:0]);
      bus_write(PWM_SCR_OFF, {pt[i][12], 7'h40});
      bus_write(TA_SCR_OFF, 8'h18);
      per = 256 * pt[i][9:8] + 5;
      dut_v = 256 * pt[i][11:10] + pt[i][7:0];
      act = pt[i][12];
      if (dut_v == per || dut_v == 0) begin
        lv = (dut_v == 0) ? ~act : act;
        m = 0;
        repeat (10) @(negedge clk);
        repeat (600) begin
          @(negedge clk);
          m += (out_a !== lv);
        end
        check(m, 0, "pwm steady");
      end else begin
        wait_lvl(1'b0, ~act, m);
        wait_lvl(1'b0, act, m);
        wait_lvl(1'b0, ~act, m);
        check(m, dut_v + 1, "pwm duty");
        wait_lvl(1'b0, act, k);
        check(m + k, per + 1, "pwm period");
      end
    end
    wrap_up();
  end
endmodule : test_timer_capture_pwm
`default_nettype wire
